// ==== rtl/switch_output_command_handler.sv ====
// Purpose: APB command front end for four switching output ports
// Assumes: host writes decoded commands into the command register
// Notes: text framing of the host link is outside this block
`timescale 1ns/10ps
`default_nettype none
module switch_output_command_handler (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // switching pins
  output logic [3:0] portOut,
  output logic [3:0] portOe
);
  port_cmd_if cmdBus ();

  logic [31:0] portCfg;
  logic [31:0] reply;
  logic [1:0] ackCode;
  logic ackValid;
  logic access;
  logic wrCmd;
  logic mapped;
  logic [1:0] op;
  logic [2:0] portNum;
  logic [3:0] mask;
  logic [3:0] vals;
  logic [31:0] next_reply;
  logic [1:0] next_ack;
  logic [31:0] readMux;

  // reply character for one port from its function and held bit
  function automatic logic [7:0] port_char(input logic [1:0] func, input logic held);
    logic [7:0] c;
    c = switch_pkg::CHAR_PASSIVE;
    case (func)
      switch_pkg::FUNC_OUTPUT: c = held ? switch_pkg::CHAR_HIGH : switch_pkg::CHAR_LOW;
      switch_pkg::FUNC_INPUT: c = switch_pkg::CHAR_INPUT;
      default: c = switch_pkg::CHAR_PASSIVE;
    endcase
    return c;
  endfunction

  // register address match, used for writes and reads
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] offs);
    return a == offs;
  endfunction

  // zero wait state slave; unmapped addresses answer with an error
  assign access = psel && penable;
  assign pready = 1'b1;
  assign mapped = addr_is(paddr, switch_pkg::CONFIG_OFFS)
    || addr_is(paddr, switch_pkg::COMMAND_OFFS)
    || addr_is(paddr, switch_pkg::STATE_OFFS)
    || addr_is(paddr, switch_pkg::REPLY_OFFS)
    || addr_is(paddr, switch_pkg::STATUS_OFFS);
  assign pslverr = access && !mapped;
  assign wrCmd = access && pwrite && addr_is(paddr, switch_pkg::COMMAND_OFFS);

  // command fields
  assign op = pwdata[switch_pkg::CMD_OP_LSB +: 2];
  assign portNum = pwdata[switch_pkg::CMD_PORT_LSB +: 3];
  assign mask = pwdata[switch_pkg::CMD_MASK_LSB +: 4];
  assign vals = pwdata[switch_pkg::CMD_VAL_LSB +: 4];

  // accepted commands to the port bank
  assign cmdBus.activate = wrCmd && op == switch_pkg::OP_ACTIVATE
    && portNum >= 3'h1 && portNum <= 3'h4;
  assign cmdBus.actPort = 2'(portNum - 3'h1);
  assign cmdBus.set = wrCmd && op == switch_pkg::OP_SET && mask != 4'h0;
  assign cmdBus.setMask = mask;
  assign cmdBus.setVal = vals;
  assign cmdBus.portFunc = portCfg[switch_pkg::CFG_FUNC_LSB +: 8];
  assign cmdBus.portInv = portCfg[switch_pkg::CFG_INV_LSB +: 4];

  switch_port_bank u_bank (
    .clk(clk),
    .rst_b(rst_b),
    .cmd(cmdBus),
    .portOut(portOut),
    .portOe(portOe)
  );

  // port configuration register, written by software
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      portCfg <= switch_pkg::CONFIG_RESET;
    end else if (access && pwrite && addr_is(paddr, switch_pkg::CONFIG_OFFS)) begin
      portCfg <= {20'h0, pwdata[11:0]};
    end
  end

  // query reply built from held bits and port functions
  always_comb begin
    next_reply = reply;
    for (int i = 0; i < switch_pkg::PORT_COUNT; i++) begin
      next_reply[8*i +: 8] = port_char(cmdBus.portFunc[2*i +: 2], cmdBus.held[i]);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reply <= switch_pkg::REPLY_RESET;
    end else if (wrCmd && op == switch_pkg::OP_QUERY) begin
      reply <= next_reply;
    end
  end

  // set acknowledgment: empty port list or bad op is a syntax error, any activate a parameter error
  always_comb begin
    next_ack = switch_pkg::ACK_OTHER;
    case (op)
      switch_pkg::OP_SET: next_ack = (mask == 4'h0) ? switch_pkg::ACK_SYNTAX
        : switch_pkg::ACK_OK;
      switch_pkg::OP_ACTIVATE: next_ack = switch_pkg::ACK_PARAM;
      switch_pkg::OP_QUERY: next_ack = switch_pkg::ACK_OTHER;
      default: next_ack = switch_pkg::ACK_SYNTAX;
    endcase
  end

  // status only answers set commands and bad opcodes; activate gives no answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ackCode <= switch_pkg::ACK_OK;
      ackValid <= 1'b0;
    end else if (wrCmd && (op == switch_pkg::OP_SET || op == 2'h0)) begin
      ackCode <= next_ack;
      ackValid <= 1'b1;
    end else if (access && !pwrite && addr_is(paddr, switch_pkg::STATUS_OFFS)) begin
      ackValid <= 1'b0; // reading status consumes it
    end
  end

  // read data selection by address
  always_comb begin
    readMux = 32'h0;
    case (paddr)
      switch_pkg::CONFIG_OFFS: readMux = portCfg;
      switch_pkg::STATE_OFFS: readMux = {28'h0, cmdBus.held};
      switch_pkg::REPLY_OFFS: readMux = reply;
      switch_pkg::STATUS_OFFS: readMux = {23'h0, ackValid, 6'h0, ackCode};
      default: readMux = 32'h0;
    endcase
  end

  // read data fetched at the setup edge so the access cycle sees a flop; zero otherwise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= readMux;
    end else begin
      prdata <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// ==== common/switch_pkg.sv ====
// Purpose: shared constants for the switching output command handler
// Assumes: APB register access, four switching ports
// Notes: codes and offsets used by the handler and the port bank
package switch_pkg;
  // port count and register widths
  localparam int PORT_COUNT = 4;
  localparam int FUNC_W = 2;
  // register byte offsets
  localparam logic [7:0] CONFIG_OFFS = 8'h00;
  localparam logic [7:0] COMMAND_OFFS = 8'h04;
  localparam logic [7:0] STATE_OFFS = 8'h08;
  localparam logic [7:0] REPLY_OFFS = 8'h0c;
  localparam logic [7:0] STATUS_OFFS = 8'h10;
  // config register fields: two function bits per port, then inversion bits
  localparam int CFG_FUNC_LSB = 0;
  localparam int CFG_INV_LSB = 8;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  // port function codes
  localparam logic [1:0] FUNC_PASSIVE = 2'h0;
  localparam logic [1:0] FUNC_INPUT = 2'h1;
  localparam logic [1:0] FUNC_OUTPUT = 2'h2;
  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_PORT_LSB = 4;
  localparam int CMD_MASK_LSB = 8;
  localparam int CMD_VAL_LSB = 12;
  // command opcodes
  localparam logic [1:0] OP_ACTIVATE = 2'h1;
  localparam logic [1:0] OP_SET = 2'h2;
  localparam logic [1:0] OP_QUERY = 2'h3;
  // reply characters
  localparam logic [7:0] CHAR_LOW = 8'h30;
  localparam logic [7:0] CHAR_HIGH = 8'h31;
  localparam logic [7:0] CHAR_INPUT = 8'h49;
  localparam logic [7:0] CHAR_PASSIVE = 8'h50;
  // set acknowledgment codes
  localparam logic [1:0] ACK_OK = 2'h0;
  localparam logic [1:0] ACK_SYNTAX = 2'h1;
  localparam logic [1:0] ACK_PARAM = 2'h2;
  localparam logic [1:0] ACK_OTHER = 2'h3;
  localparam int STATUS_VALID_BIT = 8;
  // reset values
  localparam logic [3:0] HELD_RESET = 4'h0;
  localparam logic [31:0] REPLY_RESET = 32'h5050_5050;
endpackage

// ==== common/port_cmd_if.sv ====
// Purpose: carries accepted commands and port configuration to the port bank
// Assumes: one clock domain
// Notes: pulses last one cycle
`timescale 1ns/10ps
`default_nettype none
interface port_cmd_if;
  logic activate;
  logic [1:0] actPort;
  logic set;
  logic [3:0] setMask;
  logic [3:0] setVal;
  logic [7:0] portFunc;
  logic [3:0] portInv;
  logic [3:0] held;
  // handler side issues commands, reads held states
  modport handler (output activate, actPort, set, setMask, setVal, portFunc, portInv,
    input held);
  // bank side keeps the held states
  modport bank (input activate, actPort, set, setMask, setVal, portFunc, portInv,
    output held);
endinterface
`default_nettype wire

// ==== rtl/switch_port_bank.sv ====
// Purpose: holds the logical state of each switching port and drives its pin
// Assumes: commands arrive as single-cycle pulses
// Notes: pins follow held state through the inversion bit
`timescale 1ns/10ps
`default_nettype none
module switch_port_bank (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // command carrier
  port_cmd_if.bank cmd,
  // switching pins
  output logic [3:0] portOut,
  output logic [3:0] portOe
);
  genvar i;
  generate
    for (i = 0; i < switch_pkg::PORT_COUNT; i++) begin : g_port
      logic isOut;
      assign isOut = (cmd.portFunc[2*i +: 2] == switch_pkg::FUNC_OUTPUT);
      // held bit changes only on an accepted command to an output port
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cmd.held[i] <= switch_pkg::HELD_RESET[i];
        end else if (cmd.activate && cmd.actPort == 2'(i) && isOut) begin
          cmd.held[i] <= 1'b1;
        end else if (cmd.set && cmd.setMask[i] && isOut) begin
          cmd.held[i] <= cmd.setVal[i];
        end
      end
      // pin level is logical state through inversion, driven only as output
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          portOut[i] <= 1'b0;
          portOe[i] <= 1'b0;
        end else begin
          portOut[i] <= cmd.held[i] ^ cmd.portInv[i];
          portOe[i] <= isOut;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== dv/switch_host_model.sv ====
// Purpose: host controller issuing commands over apb
// Assumes: transfer starts right after a rising edge
// Notes: request stays up after the answer until idle or next setup
`timescale 1ns/10ps
`default_nettype none
module switch_host_model (
  // clock and answer
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  // request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // setup then access until pready, data taken at that edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
  endtask
  // release; stale data is inverted so nothing relies on it
  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== dv/switch_chk.sv ====
// Purpose: port checks for the command handler
// Assumes: zero wait state apb
// Notes: bound to the top module
`timescale 1ns/10ps
`default_nettype none
module switch_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic [3:0] portOut,
  input wire logic [3:0] portOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic acc;
  logic cfgWr;
  logic sRd;
  logic [3:0] inv;
  assign acc = psel && penable;
  assign cfgWr = acc && pwrite && paddr == switch_pkg::CONFIG_OFFS;
  assign sRd = acc && !pwrite && paddr == switch_pkg::STATUS_OFFS;
  // inversion bits last written
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) inv <= 4'h0;
    else if (cfgWr) inv <= pwdata[11:8];
  end
  function automatic logic [3:0] oeOf(input logic [31:0] c);
    for (int i = 0; i < 4; i++) oeOf[i] = c[2*i+:2] == 2'h2;
  endfunction
  a_ready_high: assert property (pready == 1'b1)
    else $error("pready low");
  a_unmapped_err: assert property (acc && paddr > 8'h10 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_idle_rdata: assert property (!acc |-> prdata == 32'h0)
    else $error("read data outside access");
  a_oe_config: assert property (cfgWr |-> ##2 portOe == oeOf($past(pwdata, 2)))
    else $error("enables differ from config");
  a_oe_only_cfg: assert property ($changed(portOe) |-> $past(cfgWr, 2))
    else $error("enables moved without config");
  a_pin_invert: assert property (acc && !pwrite && paddr == 8'h08
    |-> portOut == (prdata[3:0] ^ inv))
    else $error("pin level not held state through inversion");
  a_cmd_zero: assert property (acc && !pwrite && paddr == 8'h04 |-> prdata == 32'h0)
    else $error("command register read nonzero");
  a_status_clear: assert property (sRd ##2 sRd |-> !prdata[8])
    else $error("status valid not cleared by read");
  c_cfg: cover property (cfgWr);
  c_status_twice: cover property (sRd ##2 sRd);
  c_unmapped: cover property (acc && paddr > 8'h10);
endmodule
bind switch_output_command_handler switch_chk chk_u (.clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .portOut, .portOe);
`default_nettype wire

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the command handler
// Assumes: zero wait state apb host model
// Notes: random config and commands checked against a local model
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, cfg, stat;
  logic [3:0] portOut, portOe, held, m, o;
  logic [2:0] p;
  logic [31:0] expQ[$];
  logic [7:0] pinQ[$];
  int errors = 0;
  int nTests = 0;
  always #10 clk = ~clk;
  switch_host_model host_u (.clk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
  switch_output_command_handler dut_u (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .portOut, .portOe);
  function automatic logic [31:0] nxt(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // expected reply characters per port
  function automatic logic [31:0] replyOf(input logic [31:0] c, input logic [3:0] h);
    for (int i = 0; i < 4; i++) begin
      replyOf[8*i+:8] = c[2*i+:2] == 2'h2 ? {7'h18, h[i]} : c[2*i+:2] == 2'h1 ? 8'h49 : 8'h50;
    end
  endfunction
  task automatic chk(input logic [31:0] e, input logic [31:0] a);
    nTests++;
    if (a !== e) begin
      errors++;
      $display("Error at %0t: expected %h got %h", $time, e, a);
    end
  endtask
  // pin enables and levels, compared while the state register is read
  task automatic chkPins(input logic [7:0] e, input logic [7:0] a);
    nTests++;
    if (a !== e) begin
      errors++;
      $display("Error at %0t: pins expected %h got %h", $time, e, a);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    host_u.xfer(1'b0, a, 32'h0, rd);
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // read results compared against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) chk(expQ.pop_front(), prdata);
    if (psel && penable && pready === 1'b1 && !pwrite && paddr == 8'h08) begin
      chkPins(pinQ.pop_front(), {portOe, portOut});
    end
  end
  // about 830 cycles expected; cut off far beyond
  initial begin
    #400000;
    errors++;
    conclude();
  end
  initial begin
    seed = 32'he24b;
    held = 4'h0;
    stat = 32'h0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(8'h00, 32'h0);
    rdc(8'h0c, 32'h5050_5050);
    rdc(8'h10, 32'h0);
    wr(8'h04, 32'h0);
    rdc(8'h10, 32'h101);
    rdc(8'h20, 32'h0);
    wr(8'h24, 32'hffff_ffff);
    for (int k = 0; k < 40; k++) begin
      seed = nxt(seed);
      cfg = seed & 32'hfff;
      o = {cfg[7:6] == 2'h2, cfg[5:4] == 2'h2, cfg[3:2] == 2'h2, cfg[1:0] == 2'h2};
      wr(8'h00, cfg);
      seed = nxt(seed);
      m = seed[11:8];
      wr(8'h04, {16'h0, seed[15:12], m, 8'h02});
      held = (held & ~(m & o)) | (seed[15:12] & m & o);
      stat = m != 4'h0 ? 32'h100 : 32'h101;
      p = seed[18:16];
      wr(8'h04, {24'h0, 1'b0, p, 4'h1});
      if (p >= 3'h1 && p <= 3'h4 && o[p-1]) held[p-1] = 1'b1;
      wr(8'h04, 32'h3);
      pinQ.push_back({o, held ^ cfg[11:8]});
      rdc(8'h08, {28'h0, held});
      rdc(8'h0c, replyOf(cfg, held));
      rdc(8'h00, cfg);
      rdc(8'h10, stat);
      // reading clears only the valid flag; the code stays
      rdc(8'h10, stat & 32'h3);
      rdc(8'h04, 32'h0);
    end
    host_u.idle();
    conclude();
  end
endmodule
`default_nettype wire
